/* src/pphv_pkg.sv */
/*
 * pphv_pkg: constants for the parallel high-voltage programming port.
 * Assumes a single 20 MHz core clock; all users import pphv_pkg::*.
 */
package pphv_pkg;
	// load strobe action codes
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	// synchroniser reset: load and page latch strobes low, write strobe and enable high, action code idle
	localparam logic [15:0] PIN_IDLE = 16'h0078;
	// command codes
	localparam logic [7:0] CMD_NOP      = 8'h00;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE    = 8'h11;
	localparam logic [7:0] CMD_RD_SIG   = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE    = 8'h03;
	// reset values of the nonvolatile bytes (1 = unprogrammed)
	localparam logic [7:0] FUSE_LO_RST  = 8'hff;
	localparam logic [7:0] FUSE_HI_RST  = 8'hff;
	localparam logic [7:0] FUSE_EXT_RST = 8'hff;
	localparam logic [7:0] LOCK_RST     = 8'hff;
	// lock bit positions; boot lock bits sit above the two level bits
	localparam int LOCK_LVL_A_POS = 0;
	localparam int LOCK_LVL_B_POS = 1;
	localparam logic [7:0] LOCK_BOOT_MASK = 8'h3c;
	// identity bytes: arbitrary values
	localparam logic [7:0] SIG_BYTE0 = 8'h5a;
	localparam logic [7:0] SIG_BYTE1 = 8'h01;
	localparam logic [7:0] SIG_BYTE2 = 8'h02;
	localparam logic [7:0] CAL_BYTE  = 8'h80;
	// self-timed write durations
	localparam int CLK_MHZ       = 20;
	localparam int T_FLASH_US    = 2600;
	localparam int T_EE_US       = 3600;
	localparam int T_FUSE_US     = 4500;
	localparam int FLASH_CYC     = T_FLASH_US * CLK_MHZ;
	localparam int EE_CYC        = T_EE_US * CLK_MHZ;
	localparam int FUSE_CYC      = T_FUSE_US * CLK_MHZ;
	typedef enum logic [1:0] {
		PPHV_IDLE = 2'b00,
		PPHV_BUSY = 2'b01,
		PPHV_DONE = 2'b11
	} pphv_state_t;
endpackage : pphv_pkg

/* src/pphv_port.sv */
/*
 * pphv_port: parallel high-voltage programming port with small flash,
 * eeprom, fuse and lock stores. Pins come from the programmer, outside
 * the clock domain, and are synchronised by two flip-flops here.
 */
`timescale 1ns/1ps
module pphv_port
	import pphv_pkg::*;
#(
	parameter int PAGE_WORDS  = 32,
	parameter int FLASH_WORDS = 256,
	parameter int EE_PAGE     = 4,
	parameter int EE_BYTES    = 64,
	parameter int FLASH_WAIT  = FLASH_CYC,
	parameter int EE_WAIT     = EE_CYC,
	parameter int FUSE_WAIT   = FUSE_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       clk_en,
	input  wire logic       load_strobe,
	input  wire logic       wr_strobe_n,
	input  wire logic       out_en_n,
	input  wire logic       action_select_hi,
	input  wire logic       action_select_lo,
	input  wire logic       byte_select_one,
	input  wire logic       byte_select_two,
	input  wire logic       page_latch_strobe,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe_n,
	output logic            done_flag
);
	localparam int PW = $clog2(PAGE_WORDS);
	localparam int FW = $clog2(FLASH_WORDS);
	localparam int EP = $clog2(EE_PAGE);
	localparam int EW = $clog2(EE_BYTES);

	initial begin
		if (PAGE_WORDS < 2 || PAGE_WORDS > 256 || FLASH_WORDS <= PAGE_WORDS
			|| FLASH_WORDS > 65536 || EE_BYTES <= EE_PAGE || EE_PAGE < 2
			|| EE_BYTES > 65536 || (PAGE_WORDS & (PAGE_WORDS - 1)) != 0
			|| (FLASH_WORDS & (FLASH_WORDS - 1)) != 0
			|| (EE_PAGE & (EE_PAGE - 1)) != 0
			|| (EE_BYTES & (EE_BYTES - 1)) != 0
			|| FLASH_WAIT < 1 || EE_WAIT < 1 || FUSE_WAIT < 1)
			$error("pphv_port: unsupported memory geometry");
	end

	// two-stage synchronisers for all programmer pins
	localparam int NS = 16;
	logic [NS-1:0] pin_raw, s1_reg, s2_reg, s3_reg;
	assign pin_raw = {data_in, load_strobe, wr_strobe_n, out_en_n,
		action_select_hi, action_select_lo, byte_select_one,
		byte_select_two, page_latch_strobe};
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s1_reg <= PIN_IDLE; // idle levels, so no false edge or drive
			s2_reg <= PIN_IDLE;
			s3_reg <= PIN_IDLE;
		end else if (clk_en) begin
			s1_reg <= pin_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// named views of the synchronised pins (s3 only feeds edge detection)
	logic [7:0] dbus;
	logic       ld, wrn, oen, bs1, bs2, pgl;
	logic [1:0] act;
	assign dbus = s2_reg[15:8];
	assign ld   = s2_reg[7];
	assign wrn  = s2_reg[6];
	assign oen  = s2_reg[5];
	assign act  = s2_reg[4:3];
	assign bs1  = s2_reg[2];
	assign bs2  = s2_reg[1];
	assign pgl  = s2_reg[0];

	// edge events, gated while a write runs
	logic busy, ld_rise, wr_fall, pgl_rise;
	assign busy     = !done_flag;
	assign ld_rise  = ld && !s3_reg[7] && !busy;
	assign wr_fall  = !wrn && s3_reg[6] && !busy;
	assign pgl_rise = pgl && !s3_reg[0] && !busy;

	// storage
	logic [15:0] flash_mem [FLASH_WORDS];
	logic [15:0] fpage_buf [PAGE_WORDS];
	logic [7:0]  ee_mem    [EE_BYTES];
	logic [7:0]  epage_buf [EE_PAGE];
	logic [7:0]  cmd_reg, addr_lo_reg, addr_hi_reg, dlo_reg, dhi_reg;
	logic [7:0]  fuse_lo_reg, fuse_hi_reg, fuse_ext_reg, lock_reg;
	logic [EE_PAGE-1:0] ee_dirty_reg;
	logic        wr_armed_reg;

	// address split: word within page from low bits, page from the rest
	logic [15:0] full_addr;
	logic [PW-1:0] word_idx;
	logic [FW-1:0] flash_idx, page_base;
	logic [EP-1:0] ee_word;
	logic [EW-1:0] ee_idx, ee_base;
	assign full_addr = {addr_hi_reg, addr_lo_reg};
	assign word_idx  = full_addr[PW-1:0];
	assign flash_idx = full_addr[FW-1:0];
	assign page_base = {full_addr[FW-1:PW], {PW{1'b0}}};
	assign ee_word   = full_addr[EP-1:0];
	assign ee_idx    = full_addr[EW-1:0];
	assign ee_base   = {full_addr[EW-1:EP], {EP{1'b0}}};

	// which write does a program strobe start
	logic go_flash, go_ee, go_fuse, go_lock, go_erase;
	assign go_flash = wr_fall && cmd_reg == CMD_WR_FLASH && wr_armed_reg;
	assign go_ee    = wr_fall && cmd_reg == CMD_WR_EE && !bs1;
	assign go_fuse  = wr_fall && cmd_reg == CMD_WR_FUSE;
	assign go_lock  = wr_fall && cmd_reg == CMD_WR_LOCK;
	assign go_erase = wr_fall && cmd_reg == CMD_ERASE;
	// lock level three: both level bits programmed
	logic lock_l3;
	assign lock_l3 = !lock_reg[LOCK_LVL_A_POS] && !lock_reg[LOCK_LVL_B_POS];

	// command, address and data latches driven by the load strobe
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmd_reg      <= CMD_NOP;
			addr_lo_reg  <= 8'h00;
			addr_hi_reg  <= 8'h00;
			dlo_reg      <= 8'h00;
			dhi_reg      <= 8'h00;
			wr_armed_reg <= 1'b0;
		end else if (clk_en && ld_rise) begin
			case (act)
				ACT_ADDR: begin
					if (bs1) addr_hi_reg <= dbus;
					else addr_lo_reg <= dbus;
				end
				ACT_DATA: begin
					if (bs1) dhi_reg <= dbus;
					else dlo_reg <= dbus;
				end
				ACT_CMD: begin
					cmd_reg      <= dbus;
					// nop drops the write controls; flash write re-arms
					wr_armed_reg <= (dbus == CMD_WR_FLASH);
				end
				default: ;
			endcase
		end
	end

	// page buffers filled by the page latch strobe
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ee_dirty_reg <= '0;
		end else if (clk_en) begin
			if (pgl_rise && cmd_reg == CMD_WR_FLASH)
				fpage_buf[word_idx] <= {dhi_reg, dlo_reg};
			if (go_ee)
				ee_dirty_reg <= '0;
			if (pgl_rise && cmd_reg == CMD_WR_EE) begin
				epage_buf[ee_word]    <= dlo_reg;
				ee_dirty_reg[ee_word] <= 1'b1;
			end
		end
	end

	// memory commits happen at the start of the timed write
	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			for (int i = 0; i < PAGE_WORDS; i++)
				if (go_flash)
					flash_mem[page_base + FW'(i)] <= fpage_buf[i];
			for (int j = 0; j < EE_PAGE; j++)
				if (go_ee && ee_dirty_reg[j])
					ee_mem[ee_base + EW'(j)] <= epage_buf[j];
			if (go_erase) begin
				for (int k = 0; k < FLASH_WORDS; k++)
					flash_mem[k] <= 16'hffff;
				for (int m = 0; m < EE_BYTES; m++)
					ee_mem[m] <= 8'hff;
			end
		end
	end

	// fuse and lock bytes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fuse_lo_reg  <= FUSE_LO_RST;
			fuse_hi_reg  <= FUSE_HI_RST;
			fuse_ext_reg <= FUSE_EXT_RST;
			lock_reg     <= LOCK_RST;
		end else if (clk_en) begin
			if (go_fuse && !bs1 && !bs2) fuse_lo_reg  <= dlo_reg;
			if (go_fuse && bs1 && !bs2)  fuse_hi_reg  <= dlo_reg;
			if (go_fuse && !bs1 && bs2)  fuse_ext_reg <= dlo_reg;
			// lock bits only go to zero except on erase; boot bits frozen at level 3
			if (go_lock)
				lock_reg <= lock_reg & (dlo_reg |
					(lock_l3 ? LOCK_BOOT_MASK : 8'h00));
			if (go_erase)
				lock_reg <= LOCK_RST;
		end
	end

	// self-timed write: done flag low for the whole duration
	pphv_state_t state_reg;
	logic [31:0] cnt_reg;
	logic [31:0] wait_len;
	assign wait_len = go_flash ? 32'(FLASH_WAIT) :
		go_ee ? 32'(EE_WAIT) : 32'(FUSE_WAIT);
	logic go_any;
	assign go_any = go_flash || go_ee || go_fuse || go_lock || go_erase;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg <= PPHV_IDLE;
			cnt_reg   <= 32'h0;
			done_flag <= 1'b1;
		end else if (clk_en) begin
			case (state_reg)
				PPHV_IDLE: begin
					if (go_any) begin
						state_reg <= PPHV_BUSY;
						cnt_reg   <= wait_len - 32'h1;
						done_flag <= 1'b0;
					end
				end
				PPHV_BUSY: begin
					if (cnt_reg == 32'h0)
						state_reg <= PPHV_DONE;
					else
						cnt_reg <= cnt_reg - 32'h1;
				end
				// flag rises only with idle, so no strobe is swallowed
				PPHV_DONE: begin
					state_reg <= PPHV_IDLE;
					done_flag <= 1'b1;
				end
				default:   state_reg <= PPHV_IDLE;
			endcase
		end
	end

	// read data selection
	logic [15:0] fword;
	logic [7:0]  rd_sel;
	logic [7:0]  sig_sel;
	assign fword   = flash_mem[flash_idx];
	assign sig_sel = (addr_lo_reg == 8'h00) ? SIG_BYTE0 :
		(addr_lo_reg == 8'h01) ? SIG_BYTE1 :
		(addr_lo_reg == 8'h02) ? SIG_BYTE2 : 8'hff;
	always_comb begin
		case (cmd_reg)
			CMD_RD_FLASH: rd_sel = bs1 ? fword[15:8] : fword[7:0];
			CMD_RD_EE:    rd_sel = ee_mem[ee_idx];
			CMD_RD_FUSE: begin
				case ({bs2, bs1})
					2'b00:   rd_sel = fuse_lo_reg;
					2'b11:   rd_sel = fuse_hi_reg;
					2'b10:   rd_sel = fuse_ext_reg;
					default: rd_sel = lock_reg;
				endcase
			end
			CMD_RD_SIG: rd_sel = bs1 ? CAL_BYTE : sig_sel;
			default:    rd_sel = 8'hff;
		endcase
	end

	// bus drive, registered; released when output enable is high on a clock with clock enable high
	always_ff @(posedge core_clk) begin
		if (srst) begin
			data_out  <= 8'h00;
			data_oe_n <= 1'b1;
		end else if (clk_en) begin
			data_out  <= rd_sel;
			data_oe_n <= oen;
		end
	end

	// checks
	a_busy_holds: assert property (@(posedge core_clk)
		disable iff (srst) clk_en && go_any |=> !done_flag)
		else $error("done flag did not drop on write start");
	a_strobe_gate: assert property (@(posedge core_clk)
		disable iff (srst) !done_flag |=> $stable({cmd_reg, lock_reg}))
		else $error("command or lock changed while busy");
	a_bus_drive: assert property (@(posedge core_clk)
		disable iff (srst) clk_en && !data_oe_n |-> $past(!clk_en || !oen))
		else $error("bus driven without output enable");
	a_lock_mono: assert property (@(posedge core_clk)
		disable iff (srst) clk_en && !$past(go_erase) |->
		((lock_reg & ~$past(lock_reg)) == 8'h00 || !$past(clk_en)))
		else $error("lock bit unprogrammed without erase");
	a_nop_disarm: assert property (@(posedge core_clk)
		disable iff (srst) clk_en && ld_rise && act == ACT_CMD
		&& dbus == CMD_NOP |=> !wr_armed_reg)
		else $error("nop did not clear write controls");
	a_hi_addr: assert property (@(posedge core_clk)
		disable iff (srst) clk_en && ld_rise && act == ACT_ADDR && bs1
		|=> addr_hi_reg == $past(dbus))
		else $error("high address not loaded");
	a_fuse_hi: assert property (@(posedge core_clk)
		disable iff (srst) clk_en && go_fuse && bs1 && !bs2
		|=> fuse_hi_reg == $past(dlo_reg))
		else $error("fuse high byte not written");
	a_fuse_ext: assert property (@(posedge core_clk)
		disable iff (srst) clk_en && go_fuse && !bs1 && bs2
		|=> fuse_ext_reg == $past(dlo_reg))
		else $error("extended fuse byte not written");
	c_flash_wr: cover property (@(posedge core_clk) go_flash);
	c_ee_wr:    cover property (@(posedge core_clk) go_ee);
	c_fuse_rd:  cover property (@(posedge core_clk)
		cmd_reg == CMD_RD_FUSE && !data_oe_n);
endmodule : pphv_port

/* sim/pphv_prog_model.sv */
/*
 * pphv_prog_model: behavioural programmer that drives the port's pins.
 * Assumes a free-running core_clk; pins change on its falling edge and
 * hold six cycles, above the three that the port's synchroniser and edge registers need.
 */
`timescale 1ns/1ps
module pphv_prog_model (
	input  wire logic       core_clk,
	output logic            load_strobe,
	output logic            wr_strobe_n,
	output logic            out_en_n,
	output logic            action_select_hi,
	output logic            action_select_lo,
	output logic            byte_select_one,
	output logic            byte_select_two,
	output logic            page_latch_strobe,
	output logic [7:0]      data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe_n,
	input  wire logic       done_flag
);
	logic [7:0] drv_val;
	logic [7:0] last_val = 8'h00;

	// idle pins at time zero, action code parked at no-action
	initial begin
		{load_strobe, out_en_n, wr_strobe_n} = 3'b011;
		{action_select_hi, action_select_lo} = 2'b11;
		{byte_select_one, byte_select_two} = 2'b00;
		page_latch_strobe = 1'b0;
		drv_val = 8'h00;
	end

	// wire level; a released bus toggles so a stale value never passes
	always_comb begin
		if (!data_oe_n)
			data_in = data_out;
		else if (out_en_n)
			data_in = drv_val;
		else
			data_in = ~last_val;
	end
	always @(posedge core_clk) last_val <= data_in;

	task automatic hold(input int n);
		repeat (n) @(negedge core_clk);
	endtask : hold

	// one load strobe pulse; the action code gives the byte its meaning
	task automatic ld(input logic [1:0] act, input logic bs1,
		input logic [7:0] val);
		{action_select_hi, action_select_lo} = act;
		byte_select_one = bs1;
		drv_val = val;
		hold(6);
		load_strobe = 1'b1;
		hold(6);
		load_strobe = 1'b0;
		hold(6);
	endtask : ld

	// page latch with high byte selected, once per loaded word
	task automatic latch;
		byte_select_one = 1'b1;
		hold(6);
		page_latch_strobe = 1'b1;
		hold(6);
		page_latch_strobe = 1'b0;
		hold(6);
	endtask : latch

	// program strobe; seen is the done flag while the strobe is low
	task automatic wr(input logic bs1, input logic bs2, output logic seen);
		byte_select_one = bs1;
		byte_select_two = bs2;
		hold(6);
		wr_strobe_n = 1'b0;
		hold(6);
		seen = done_flag;
		wr_strobe_n = 1'b1;
		hold(6);
		byte_select_one = 1'b0;
		byte_select_two = 1'b0;
		hold(2);
	endtask : wr

	// read cycle: programmer lets go of the bus while output enable is low
	task automatic rd(input logic bs1, input logic bs2,
		output logic [7:0] val, output logic oe);
		byte_select_one = bs1;
		byte_select_two = bs2;
		out_en_n = 1'b0;
		hold(6);
		val = data_in;
		oe = data_oe_n;
		out_en_n = 1'b1;
		{byte_select_one, byte_select_two} = 2'b00;
		hold(6);
	endtask : rd
endmodule : pphv_prog_model

/* sim/testbench.sv */
/*
 * testbench: self-checking bench for pphv_port with a programmer model.
 * Assumes the shortened write waits below; expectations come from pphv_pkg.
 */
`timescale 1ns/1ps
module testbench;
	import pphv_pkg::*;
	localparam int FW = 8;
	localparam int EW = 8;
	localparam int UW = 40;
	logic       core_clk = 1'b0;
	logic       srst     = 1'b1;
	logic       clk_en   = 1'b1;
	logic       ld_s, wr_n, oe_n, xh, xl, bs1, bs2, pl, oe_dev, done_flag;
	logic [7:0] d_in, d_out;
	int         num_errors  = 0;
	int         checks_done = 0;

	always #25 core_clk = ~core_clk;

	pphv_port #(.FLASH_WAIT(FW), .EE_WAIT(EW), .FUSE_WAIT(UW)) u_dut (
		.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
		.load_strobe(ld_s), .wr_strobe_n(wr_n), .out_en_n(oe_n),
		.action_select_hi(xh), .action_select_lo(xl),
		.byte_select_one(bs1), .byte_select_two(bs2),
		.page_latch_strobe(pl), .data_in(d_in), .data_out(d_out),
		.data_oe_n(oe_dev), .done_flag(done_flag));
	pphv_prog_model u_prog (
		.core_clk(core_clk), .load_strobe(ld_s), .wr_strobe_n(wr_n),
		.out_en_n(oe_n), .action_select_hi(xh), .action_select_lo(xl),
		.byte_select_one(bs1), .byte_select_two(bs2),
		.page_latch_strobe(pl), .data_in(d_in), .data_out(d_out),
		.data_oe_n(oe_dev), .done_flag(done_flag));

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// boot bits freeze once both level bits are programmed
	function automatic logic [7:0] lock_exp(input logic [7:0] cur,
		input logic [7:0] d);
		logic [7:0] keep;
		keep = (cur[1:0] == 2'h0) ? LOCK_BOOT_MASK : 8'h00;
		return cur & (d | keep);
	endfunction : lock_exp

	task automatic cmd(input logic [7:0] c);
		u_prog.ld(ACT_CMD, 1'b0, c);
	endtask : cmd

	// bounded wait for ready
	task automatic wait_done;
		int n;
		n = 0;
		while (done_flag !== 1'b1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		chk({7'h0, done_flag}, 8'h01);
	endtask : wait_done

	task automatic wrchk(input logic b1, input logic b2, input logic busy);
		logic seen;
		u_prog.wr(b1, b2, seen);
		chk({7'h0, seen}, {7'h0, ~busy});
		wait_done();
	endtask : wrchk

	task automatic rdchk(input logic b1, input logic b2,
		input logic [7:0] exp);
		logic [7:0] v;
		logic       oe;
		u_prog.rd(b1, b2, v, oe);
		chk(v, exp);
		chk({7'h0, oe}, 8'h00);
		chk({7'h0, oe_dev}, 8'h01);
	endtask : rdchk

	// main sequence: fuses, flash, eeprom, signature, lock bits
	initial begin
		logic [7:0]  d0, d1, a, base, lk, e[4], sig[3], lkv[3];
		logic [15:0] w[2];
		logic [2:0]  pg;
		logic        seen;
		void'($urandom(55692));
		sig = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
		lkv = '{8'hfc, 8'hc3, 8'hff};
		repeat (10) @(negedge core_clk);
		srst = 1'b0;
		chk({6'h0, done_flag, oe_dev}, 8'h03);
		chk(d_out, 8'h00);
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		cmd(CMD_WR_FUSE);
		u_prog.ld(ACT_DATA, 1'b0, d0);
		u_prog.wr(1'b0, 1'b0, seen);
		chk({7'h0, seen}, 8'h00);
		// frozen clock enable must hold the write longer than its wait
		clk_en = 1'b0;
		repeat (60) @(negedge core_clk);
		chk({7'h0, done_flag}, 8'h00);
		clk_en = 1'b1;
		u_prog.ld(ACT_DATA, 1'b0, d1);
		wait_done();
		wrchk(1'b1, 1'b0, 1'b1);
		u_prog.ld(ACT_DATA, 1'b0, d1);
		wrchk(1'b0, 1'b1, 1'b1);
		cmd(CMD_RD_FUSE);
		rdchk(1'b0, 1'b0, d0);
		rdchk(1'b1, 1'b1, d0);
		rdchk(1'b0, 1'b1, d1);
		rdchk(1'b1, 1'b0, LOCK_RST);
		pg = 3'($urandom_range(7, 0));
		cmd(CMD_WR_FLASH);
		u_prog.ld(ACT_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++) begin
			w[i] = 16'($urandom);
			a = {pg, (i == 0) ? 5'h00 : 5'h1f};
			u_prog.ld(ACT_ADDR, 1'b0, a);
			u_prog.ld(ACT_DATA, 1'b0, w[i][7:0]);
			u_prog.ld(ACT_DATA, 1'b1, w[i][15:8]);
			u_prog.latch();
		end
		wrchk(1'b0, 1'b0, 1'b1);
		cmd(CMD_NOP);
		wrchk(1'b0, 1'b0, 1'b0);
		cmd(CMD_RD_FLASH);
		u_prog.ld(ACT_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++) begin
			u_prog.ld(ACT_ADDR, 1'b0, {pg, (i == 0) ? 5'h00 : 5'h1f});
			rdchk(1'b0, 1'b0, w[i][7:0]);
			rdchk(1'b1, 1'b0, w[i][15:8]);
		end
		base = {2'h0, 4'($urandom), 2'h0};
		cmd(CMD_WR_EE);
		u_prog.ld(ACT_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 4; i++) begin
			e[i] = 8'($urandom);
			u_prog.ld(ACT_ADDR, 1'b0, base + 8'(i));
			u_prog.ld(ACT_DATA, 1'b0, e[i]);
			u_prog.latch();
		end
		wrchk(1'b1, 1'b0, 1'b0);
		wrchk(1'b0, 1'b0, 1'b1);
		cmd(CMD_RD_EE);
		u_prog.ld(ACT_ADDR, 1'b1, 8'h00);
		for (int i = 0; i < 4; i++) begin
			u_prog.ld(ACT_ADDR, 1'b0, base + 8'(i));
			rdchk(1'b0, 1'b0, e[i]);
		end
		cmd(CMD_RD_SIG);
		for (int i = 0; i < 3; i++) begin
			u_prog.ld(ACT_ADDR, 1'b0, 8'(i));
			rdchk(1'b0, 1'b0, sig[i]);
		end
		u_prog.ld(ACT_ADDR, 1'b0, 8'h00);
		u_prog.ld(ACT_IDLE, 1'b0, 8'h02);
		rdchk(1'b0, 1'b0, SIG_BYTE0);
		rdchk(1'b1, 1'b0, CAL_BYTE);
		lk = LOCK_RST;
		for (int i = 0; i < 3; i++) begin
			cmd(CMD_WR_LOCK);
			u_prog.ld(ACT_DATA, 1'b0, lkv[i]);
			u_prog.wr(1'b0, 1'b0, seen);
			wait_done();
			lk = lock_exp(lk, lkv[i]);
		end
		cmd(CMD_RD_FUSE);
		rdchk(1'b1, 1'b0, lk);
		// erase clears lock bits and memories, keeps the fuses
		cmd(CMD_ERASE);
		wrchk(1'b0, 1'b0, 1'b1);
		cmd(CMD_RD_FUSE);
		rdchk(1'b1, 1'b0, LOCK_RST);
		rdchk(1'b0, 1'b0, d0);
		cmd(CMD_RD_EE);
		rdchk(1'b0, 1'b0, 8'hff);
		cmd(CMD_RD_FLASH);
		rdchk(1'b1, 1'b0, 8'hff);
		tally_and_finish();
	end

	// watchdog well beyond the expected run length
	initial begin
		#(20000 * 50);
		num_errors++;
		$display("BAD %0t run did not complete", $time);
		tally_and_finish();
	end
endmodule : testbench
